/* gpio_irq_pkg.sv */
// Constants, register map and carrier types for the port mode and pin interrupt block.
`default_nettype none

package gpio_irq_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_P0_FLAGS = 8'h89;
  localparam logic [7:0] IDX_P1_FLAGS = 8'h8A;
  localparam logic [7:0] IDX_P2_FLAGS = 8'h8B;
  localparam logic [7:0] IDX_CONTROL = 8'h8C;
  localparam logic [7:0] IDX_P1_PIN_EN = 8'h8D;
  localparam logic [7:0] IDX_EVT_STATUS = 8'h90;
  localparam logic [7:0] IDX_EVT_MASK = 8'h91;
  localparam logic [7:0] IDX_P1_MODE = 8'hF6;
  localparam logic [7:0] IDX_P2_MODE = 8'hF7;

  // Reset values.
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  localparam logic [7:0] RST_P1_PIN_EN = 8'h00;
  localparam logic [5:0] RST_P1_MODE = 6'h00;
  localparam logic [7:0] RST_P2_MODE = 8'h00;
  localparam logic [2:0] RST_EVT = 3'h0;

  // Control register fields.
  localparam int CTL_DRIVE = 6;
  localparam int CTL_P2_EN = 5;
  localparam int CTL_P0_HI_EN = 4;
  localparam int CTL_P0_LO_EN = 3;
  localparam int CTL_P2_EDGE = 2;
  localparam int CTL_P1_EDGE = 1;
  localparam int CTL_P0_EDGE = 0;

  // Port 2 mode register fields.
  localparam int P2M_PD2 = 7;
  localparam int P2M_PD1 = 6;
  localparam int P2M_PD0 = 5;

  // Port 1 mode bits start at this pin.
  localparam int P1M_LSB = 2;

  // Event status bits: one per port request rising.
  localparam int EVT_P0 = 0;
  localparam int EVT_P1 = 1;
  localparam int EVT_P2 = 2;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic p0PulldownSel;
    logic p1PulldownSel;
    logic p2PulldownSel;
    logic [7:0] p1TristateSel;
    logic [4:0] p2TristateSel;
    logic padDriveStrength;
  } pad_cfg_t;

endpackage : gpio_irq_pkg

`default_nettype wire

/* port_irq_ctrl.sv */
// Port input mode, pad drive and pin interrupt flag logic behind an Avalon-MM slave.
`default_nettype none

module port_irq_ctrl
  import gpio_irq_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Avalon-MM slave.
  input wire avmm_req_t avs,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Port pins seen as inputs.
  input wire logic [7:0] p0In,
  input wire logic [7:0] p1In,
  input wire logic [4:0] p2In,
  // Pad configuration.
  output pad_cfg_t padCfg,
  // Interrupts.
  output logic [2:0] portIrq,
  output logic irq
);

  function automatic logic [7:0] edgeHit(input logic [7:0] prev, input logic [7:0] cur,
                                         input logic falling);
    edgeHit = falling ? (prev & ~cur) : (~prev & cur);
  endfunction : edgeHit

  logic [1:0] rstPipe;
  logic rstN;
  logic [7:0] p0Meta, p0Sync, p0Prev;
  logic [7:0] p1Meta, p1Sync, p1Prev;
  logic [4:0] p2Meta, p2Sync, p2Prev;
  logic [7:0] p0Flags, p1Flags;
  logic [4:0] p2Flags;
  logic [6:0] control;
  logic [7:0] p1PinEn;
  logic [5:0] p1Mode;
  logic [7:0] p2Mode;
  logic [2:0] evtStatus, evtMask;
  logic ack;
  logic accept, wrLow, rdAccept;
  logic [7:0] p0Edge, p1Edge, p2EdgeW;
  logic [2:0] next_portIrq;
  logic [7:0] rdValue;

  // Reset is released through two flops so every register leaves reset on the same edge.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // Pins are asynchronous; the first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      p0Meta <= 8'h00;
      p0Sync <= 8'h00;
      p0Prev <= 8'h00;
      p1Meta <= 8'h00;
      p1Sync <= 8'h00;
      p1Prev <= 8'h00;
      p2Meta <= 5'h00;
      p2Sync <= 5'h00;
      p2Prev <= 5'h00;
    end else begin
      p0Meta <= p0In;
      p0Sync <= p0Meta;
      p0Prev <= p0Sync;
      p1Meta <= p1In;
      p1Sync <= p1Meta;
      p1Prev <= p1Sync;
      p2Meta <= p2In;
      p2Sync <= p2Meta;
      p2Prev <= p2Sync;
    end
  end

  // History flops leave reset low, so a pin that is already high at release looks like a
  // rising edge once; software should clear the flags once after reset.
  assign p0Edge = edgeHit(p0Prev, p0Sync, control[CTL_P0_EDGE]);
  assign p1Edge = edgeHit(p1Prev, p1Sync, control[CTL_P1_EDGE]);
  assign p2EdgeW = edgeHit({3'h0, p2Prev}, {3'h0, p2Sync}, control[CTL_P2_EDGE]);

  // Bus handshake: one wait cycle, then the request is accepted at the edge where
  // waitrequest is low.
  assign accept = (avs.read | avs.write) & ack;
  assign wrLow = accept & avs.write & avs.byteenable[0];
  assign rdAccept = accept & avs.read;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      ack <= 1'b0;
      avsWaitrequest <= 1'b1;
    end else begin
      ack <= (avs.read | avs.write) & ~ack;
      avsWaitrequest <= ~((avs.read | avs.write) & ~ack);
    end
  end

  // Pin flags: an edge in the clearing cycle wins over the clear.
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      p0Flags <= RST_FLAGS;
      p1Flags <= RST_FLAGS;
      p2Flags <= RST_FLAGS[4:0];
    end else begin
      p0Flags <= (p0Flags & ~((wrLow && avs.address == IDX_P0_FLAGS) ?
                  ~avs.writedata[7:0] : 8'h00)) | p0Edge;
      p1Flags <= (p1Flags & ~((wrLow && avs.address == IDX_P1_FLAGS) ?
                  ~avs.writedata[7:0] : 8'h00)) | p1Edge;
      p2Flags <= (p2Flags & ~((wrLow && avs.address == IDX_P2_FLAGS) ?
                  ~avs.writedata[4:0] : 5'h00)) | p2EdgeW[4:0];
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      control <= RST_CONTROL;
      p1PinEn <= RST_P1_PIN_EN;
      p1Mode <= RST_P1_MODE;
      p2Mode <= RST_P2_MODE;
      evtMask <= RST_EVT;
    end else if (wrLow) begin
      unique case (avs.address)
        IDX_CONTROL: control <= avs.writedata[6:0];
        IDX_P1_PIN_EN: p1PinEn <= avs.writedata[7:0];
        IDX_P1_MODE: p1Mode <= avs.writedata[7:2];
        IDX_P2_MODE: p2Mode <= avs.writedata[7:0];
        IDX_EVT_MASK: evtMask <= avs.writedata[2:0];
        default: ;
      endcase
    end
  end

  // Per-port requests, gated by the group enables for ports 0 and 2 and by the per-pin enables for port 1.
  always_comb begin
    next_portIrq[EVT_P0] = (|p0Flags[7:4] & control[CTL_P0_HI_EN])
                         | (|p0Flags[3:0] & control[CTL_P0_LO_EN]);
    next_portIrq[EVT_P1] = |(p1Flags & p1PinEn);
    next_portIrq[EVT_P2] = |p2Flags & control[CTL_P2_EN];
  end

  // Event status records each new port request; a read of the register clears it,
  // but a request that rises in that same cycle survives the clear.
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      portIrq <= RST_EVT;
      evtStatus <= RST_EVT;
      irq <= 1'b0;
    end else begin
      portIrq <= next_portIrq;
      evtStatus <= ((rdAccept && avs.address == IDX_EVT_STATUS) ? RST_EVT : evtStatus)
                   | (next_portIrq & ~portIrq);
      irq <= |(evtStatus & evtMask);
    end
  end

  // Read mux; unused bits read zero and unmapped indices read zero.
  always_comb begin
    unique case (avs.address)
      IDX_P0_FLAGS: rdValue = p0Flags;
      IDX_P1_FLAGS: rdValue = p1Flags;
      IDX_P2_FLAGS: rdValue = {3'h0, p2Flags};
      IDX_CONTROL: rdValue = {1'b0, control};
      IDX_P1_PIN_EN: rdValue = p1PinEn;
      IDX_EVT_STATUS: rdValue = {5'h00, evtStatus};
      IDX_EVT_MASK: rdValue = {5'h00, evtMask};
      IDX_P1_MODE: rdValue = {p1Mode, 2'h0};
      IDX_P2_MODE: rdValue = p2Mode;
      default: rdValue = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      avsReaddata <= 32'h0000_0000;
    end else if (avs.read & ~ack) begin
      avsReaddata <= {24'h00_0000, rdValue};
    end
  end

  // Pad configuration is registered once more from the register flops, one cycle later.
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      padCfg <= '0;
    end else begin
      padCfg.p0PulldownSel <= p2Mode[P2M_PD0];
      padCfg.p1PulldownSel <= p2Mode[P2M_PD1];
      padCfg.p2PulldownSel <= p2Mode[P2M_PD2];
      padCfg.p1TristateSel <= {p1Mode, 2'h0};
      padCfg.p2TristateSel <= p2Mode[4:0];
      padCfg.padDriveStrength <= control[CTL_DRIVE];
    end
  end

endmodule : port_irq_ctrl

`default_nettype wire

/* port_irq_ctrl_properties.sv */
// Assertions on the ports of the port mode and pin interrupt block.
`default_nettype none
module port_irq_ctrl_checker
  import gpio_irq_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus and pins.
  input wire avmm_req_t avs,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic [7:0] p0In,
  input wire logic [7:0] p1In,
  input wire logic [4:0] p2In,
  // Outputs.
  input wire pad_cfg_t padCfg,
  input wire logic [2:0] portIrq,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic acc = !avsWaitrequest && (avs.read || avs.write);
  wire logic wr = acc && avs.write && avs.byteenable[0];
  wire logic wrCtl = wr && avs.address == IDX_CONTROL;
  wire logic wrMode = wr && avs.address == IDX_P2_MODE;
  property p_p1lo; padCfg.p1TristateSel[1:0] == 2'b00; endproperty
  a_p1lo: assert property (p_p1lo) else $error("port 1 low mode bits set");
  property p_p2rd;
    acc && avs.read && avs.address == IDX_P2_FLAGS |-> avsReaddata[7:5] == 3'h0;
  endproperty
  a_p2rd: assert property (p_p2rd) else $error("port 2 flag spare bits set");
  property p_tri2; wrMode |-> ##2 padCfg.p2TristateSel == $past(avs.writedata[4:0], 2); endproperty
  a_tri2: assert property (p_tri2) else $error("port 2 mode not applied");
  property p_pd2; wrMode |-> ##2 padCfg.p2PulldownSel == $past(avs.writedata[7], 2); endproperty
  a_pd2: assert property (p_pd2) else $error("port 2 pull select wrong");
  property p_pd1; wrMode |-> ##2 padCfg.p1PulldownSel == $past(avs.writedata[6], 2); endproperty
  a_pd1: assert property (p_pd1) else $error("port 1 pull select wrong");
  property p_pd0; wrMode |-> ##2 padCfg.p0PulldownSel == $past(avs.writedata[5], 2); endproperty
  a_pd0: assert property (p_pd0) else $error("port 0 pull select wrong");
  property p_drv; wrCtl |-> ##2 padCfg.padDriveStrength == $past(avs.writedata[6], 2); endproperty
  a_drv: assert property (p_drv) else $error("drive strength not applied");
  property p_en2; wrCtl && !avs.writedata[5] |-> ##2 !portIrq[2]; endproperty
  a_en2: assert property (p_en2) else $error("port 2 request while disabled");
  property p_en0; wrCtl && avs.writedata[4:3] == 2'b00 |-> ##2 !portIrq[0]; endproperty
  a_en0: assert property (p_en0) else $error("port 0 request while disabled");
endmodule : port_irq_ctrl_checker

bind port_irq_ctrl port_irq_ctrl_checker chk (.clk_sys(clk_sys), .reset_n(reset_n), .avs(avs),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .p0In(p0In), .p1In(p1In),
  .p2In(p2In), .padCfg(padCfg), .portIrq(portIrq), .irq(irq));
`default_nettype wire

/* port_input_mode_and_pin_interrupts_bench.sv */
// Self-checking bench for the port mode and pin interrupt block.
`default_nettype none
module port_input_mode_and_pin_interrupts_bench import gpio_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  avmm_req_t avs = '0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [7:0] p0In = 8'h00;
  logic [7:0] p1In = 8'h00;
  logic [4:0] p2In = 5'h00;
  pad_cfg_t padCfg;
  logic [2:0] portIrq;
  logic irq;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] rdw;
  logic [7:0] d, v0, v1;
  logic [4:0] v2;
  port_irq_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .avs(avs), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .p0In(p0In), .p1In(p1In), .p2In(p2In), .padCfg(padCfg),
    .portIrq(portIrq), .irq(irq));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One idle cycle follows each access so the strobes never change twice in one step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int n = 0;
    avs <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: {24'h0, wd}};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("[ERR] %0t bus timeout", $time);
      conclude();
    end else begin
      rdw = avsReaddata;
      avs.read <= 1'b0;
      avs.write <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : bus
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdw, {24'h0, e});
  endtask : rdChk
  function automatic logic [7:0] rdExp(input logic [7:0] a, input logic [7:0] v);
    case (a)
      IDX_P1_MODE: return v & 8'hFC;
      IDX_CONTROL: return v & 8'h7F;
      default: return v;
    endcase
  endfunction : rdExp
  initial begin
    void'($urandom(99985));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b1, 8'h00, 8'hFF);
    rdChk(8'h00, 8'h00);
    rdChk(IDX_P1_MODE, 8'h00);
    rdChk(IDX_P2_FLAGS, 8'h00);
    $display("reset and unmapped test done");
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 8'hFF : 8'($urandom);
      bus(1'b1, IDX_P1_MODE, d);
      rdChk(IDX_P1_MODE, rdExp(IDX_P1_MODE, d));
      chk(padCfg.p1TristateSel, {d[7:2], 2'b00});
      bus(1'b1, IDX_P2_MODE, d);
      rdChk(IDX_P2_MODE, d);
      chk({padCfg.p2PulldownSel, padCfg.p1PulldownSel, padCfg.p0PulldownSel,
           padCfg.p2TristateSel}, d);
      bus(1'b1, IDX_CONTROL, d & 8'hC0);
      rdChk(IDX_CONTROL, rdExp(IDX_CONTROL, d & 8'hC0));
      chk(padCfg.padDriveStrength, d[6]);
    end
    $display("mode test done");
    v0 = 8'($urandom) | 8'h01;
    v1 = 8'($urandom);
    v2 = 5'($urandom) | 5'h01;
    p0In <= v0;
    p1In <= v1;
    p2In <= v2;
    repeat (8) @(posedge clk_sys);
    rdChk(IDX_P0_FLAGS, v0);
    rdChk(IDX_P1_FLAGS, v1);
    rdChk(IDX_P2_FLAGS, {3'h0, v2});
    d = 8'($urandom);
    bus(1'b1, IDX_P0_FLAGS, d);
    rdChk(IDX_P0_FLAGS, v0 & d);
    bus(1'b1, IDX_P0_FLAGS, 8'h00);
    bus(1'b1, IDX_P1_FLAGS, 8'h00);
    rdChk(IDX_P1_FLAGS, 8'h00);
    bus(1'b1, IDX_CONTROL, 8'h01);
    p0In <= 8'h00;
    repeat (8) @(posedge clk_sys);
    rdChk(IDX_P0_FLAGS, v0);
    $display("flag test done");
    // The mask stays clear at first, so the port requests are checked before events reach irq.
    bus(1'b1, IDX_CONTROL, 8'h39);
    repeat (8) @(posedge clk_sys);
    chk({portIrq, irq}, 4'hA);
    bus(1'b1, IDX_EVT_MASK, 8'h07);
    repeat (4) @(posedge clk_sys);
    chk(irq, 1'b1);
    rdChk(IDX_EVT_STATUS, 8'h05);
    repeat (4) @(posedge clk_sys);
    chk(irq, 1'b0);
    bus(1'b1, IDX_CONTROL, 8'h11);
    repeat (4) @(posedge clk_sys);
    chk(portIrq, {2'b00, |v0[7:4]});
    $display("interrupt test done");
    // Falling edges on ports 1 and 2, and the port 1 per-pin enables.
    bus(1'b1, IDX_P2_FLAGS, 8'h00);
    bus(1'b1, IDX_CONTROL, 8'h06);
    p1In <= 8'h00;
    p2In <= 5'h00;
    repeat (8) @(posedge clk_sys);
    rdChk(IDX_P1_FLAGS, v1);
    rdChk(IDX_P2_FLAGS, {3'h0, v2});
    bus(1'b1, IDX_P1_PIN_EN, 8'hFF);
    repeat (4) @(posedge clk_sys);
    chk(portIrq, {1'b0, |v1, 1'b0});
    $display("falling edge test done");
    conclude();
  end
endmodule : port_input_mode_and_pin_interrupts_bench
`default_nettype wire
